// ==== mmd_pkg.sv ====
package mmd_pkg;

    // Register indices; the APB byte address is four times the index.
    localparam logic [15:0] CTRL_INDEX = 16'h0fd0;
    localparam logic [15:0] KEY_INDEX = 16'h0fd1;
    localparam logic [15:0] CTRL_ADDR = 16'(CTRL_INDEX * 4);
    localparam logic [15:0] KEY_ADDR = 16'(KEY_INDEX * 4);

    // Control register reset value and the loader map enable field position.
    localparam logic [7:0] CTRL_RESET = 8'h40;
    localparam int MAP_EN_BIT = 0;

    // Only this key value copies the buffer into the shadow.
    localparam logic [7:0] MAP_KEY_CODE = 8'hd5;

    // Fill values returned where nothing is mapped.
    localparam logic [7:0] LOADER_HOLE_FILL = 8'hff;
    localparam logic [7:0] OPEN_BUS_FILL = 8'h00;

    // Address windows of the two spaces.
    localparam logic [15:0] SFR1_LO = 16'h0000;
    localparam logic [15:0] SFR1_HI = 16'h003f;
    localparam logic [15:0] SFR2_LO = 16'h0f00;
    localparam logic [15:0] SFR2_HI = 16'h0fff;
    localparam logic [15:0] SFR3_LO = 16'h0e40;
    localparam logic [15:0] SFR3_HI = 16'h0eff;
    localparam logic [15:0] RAM_LO = 16'h0040;
    localparam logic [15:0] RAM_HI = 16'h083f;
    localparam logic [15:0] LOADER_LO = 16'h1000;
    localparam logic [15:0] LOADER_HI = 16'h17ff;
    localparam logic [15:0] FLASH_LO = 16'hc000;
    localparam logic [15:0] FLASH_HI = 16'hffff;

    // Loader offset bit that is forced low outside serial boot mode.
    localparam int LOADER_HIGH_BIT = 11;

    // Target of one decoded access.
    typedef enum logic [2:0] {
        RGN_NONE,
        RGN_SFR,
        RGN_RAM,
        RGN_LOADER,
        RGN_FLASH,
        RGN_HOLE,
        RGN_TRAP
    } mmd_region_e;

    // One CPU access as issued by the core.
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mmd_req_s;

    // Selects and address toward the memory arrays.
    typedef struct packed {
        logic sfrSel;
        logic ramSel;
        logic loaderSel;
        logic flashSel;
        logic write;
        logic [15:0] offset;
        logic [7:0] wdata;
    } mmd_mem_s;

    // Answer returned to the core.
    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } mmd_rsp_s;

endpackage : mmd_pkg

// ==== mmd_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for one level from a pin.
module mmd_sync2 (
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);

    // First stage; only the second stage reads it.
    logic meta_q;

    // Both stages clear at reset so the level reads as low until it settles.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule : mmd_sync2
`default_nettype wire

// ==== mmd_space_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

// Combinational decoder for one address space, code or data.
module mmd_space_decoder #(
    parameter bit IS_CODE = 1'b0,
    parameter bit FLASH_UNDER_LOADER = 1'b0
) (
    input wire logic [15:0] addr,
    input wire logic mapEn,
    input wire logic serialBoot,
    output mmd_pkg::mmd_region_e region,
    output logic [15:0] offset
);

    // Window hits.
    logic inSfr;
    logic inRam;
    logic inLoader;
    logic inFlash;

    assign inSfr = (addr <= mmd_pkg::SFR1_HI)
        || (addr >= mmd_pkg::SFR2_LO && addr <= mmd_pkg::SFR2_HI)
        || (addr >= mmd_pkg::SFR3_LO && addr <= mmd_pkg::SFR3_HI);
    assign inRam = addr >= mmd_pkg::RAM_LO && addr <= mmd_pkg::RAM_HI;
    assign inLoader = addr >= mmd_pkg::LOADER_LO && addr <= mmd_pkg::LOADER_HI;
    assign inFlash = addr >= mmd_pkg::FLASH_LO;

    // Region choice; the windows do not overlap, so order only matters for clarity.
    always_comb begin
        region = mmd_pkg::RGN_NONE;
        offset = addr;
        if (inLoader) begin
            offset = addr - mmd_pkg::LOADER_LO;
            // The upper half of the loader is reachable only in serial boot mode.
            offset[mmd_pkg::LOADER_HIGH_BIT] = serialBoot;
            if (mapEn) begin
                region = mmd_pkg::RGN_LOADER;
            end else if (!IS_CODE) begin
                region = mmd_pkg::RGN_HOLE;
            end else if (FLASH_UNDER_LOADER) begin
                region = mmd_pkg::RGN_FLASH;
                offset = addr;
            end else begin
                region = mmd_pkg::RGN_TRAP;
            end
        end else if (inFlash) begin
            region = mmd_pkg::RGN_FLASH;
            offset = addr - mmd_pkg::FLASH_LO;
        end else if (!IS_CODE && inSfr) begin
            region = mmd_pkg::RGN_SFR;
        end else if (!IS_CODE && inRam) begin
            region = mmd_pkg::RGN_RAM;
            offset = addr - mmd_pkg::RAM_LO;
        end
    end

endmodule : mmd_space_decoder
`default_nettype wire

// ==== mmd_memory_map_decoder.sv ====
// Behaviour
// - Map enabled: 0x1000-0x17FF hits loader ROM.
// - Loader ROM unmapped after reset release.
// - Control writes buffer; key 0xD5 commits shadow.
// - Software can read back the shadow.
// - Unmapped loader window reads 0xFF in data.
// - Only first 2 Kbytes outside serial boot.
// - Code 0xC000-0xFFFF decodes to Flash.
// - Data 0xC000-0xFFFF decodes to Flash.
// - Three SFR windows decoded in data space.
// - Data 0x0040-0x083F decodes to RAM.
// - Control resets 0x40; key is write-only.
// - Unmapped loader fetch gives Flash or trap opcode.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Memory map decoder for the code and data spaces of the core.
// The core issues at most one fetch and one data access per clock.
// Each access is decoded in the cycle it is presented, so the arrays
// see their select and offset in that same cycle.
// The arrays are synchronous and return their byte one clock later.
// The answer to the core is registered once more, two edges in total.
// This costs one cycle of latency but keeps the answer path short.
// The loader window is the only place whose meaning can change at run time.
// Its meaning changes through the shadow copy of the control byte and through the synchronised boot strap.
// Software writes the control byte freely; nothing moves until the key arrives.
// That double buffer lets software stage a setting without a glitch.
// A limitation: RAM in the code space and vector relocation are not handled here.
// Those belong to the system control logic, which sits elsewhere.
module mmd_memory_map_decoder #(
    parameter bit FLASH_UNDER_LOADER = 1'b0,
    parameter logic [7:0] TRAP_OPCODE = 8'hff
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic serialBootPin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mmd_pkg::mmd_req_s codeReq,
    input wire mmd_pkg::mmd_req_s dataReq,
    output mmd_pkg::mmd_mem_s codeMem,
    output mmd_pkg::mmd_mem_s dataMem,
    input wire logic [7:0] flashCodeRdata,
    input wire logic [7:0] loaderCodeRdata,
    input wire logic [7:0] sfrRdata,
    input wire logic [7:0] ramRdata,
    input wire logic [7:0] loaderDataRdata,
    input wire logic [7:0] flashDataRdata,
    output mmd_pkg::mmd_rsp_s codeRsp,
    output mmd_pkg::mmd_rsp_s dataRsp,
    output logic loaderRomMapEnable
);

    // Buffered control value; software writes land here first.
    logic [7:0] ctrlBuf_q;
    // Effective shadow; only this copy steers the map.
    logic [7:0] shadow_q;
    // Serial boot level after two flops.
    logic serialBoot;

    // Decoder results for both spaces.
    mmd_pkg::mmd_region_e codeRegion;
    mmd_pkg::mmd_region_e dataRegion;
    logic [15:0] codeOffset;
    logic [15:0] dataOffset;

    // Region of the access whose array data arrives this cycle.
    mmd_pkg::mmd_region_e codeRegion_q;
    mmd_pkg::mmd_region_e dataRegion_q;
    logic codePend_q;
    logic dataPend_q;

    // APB decode terms.
    logic apbAccess;
    logic hitCtrl;
    logic hitKey;
    logic lowLaneWrite;

    // The boot-mode strap comes from a pin, so it is synchronised first.
    // For two edges after reset the strap therefore reads as low.
    // During that time only the lower half of the loader is reachable.
    // No fetch from the loader can happen then anyway, as the map is off.
    mmd_sync2 bootSync (
        .clk(clk),
        .reset(reset),
        .din(serialBootPin),
        .dout(serialBoot)
    );

    // The effective enable bit, visible to the rest of the chip.
    assign loaderRomMapEnable = shadow_q[mmd_pkg::MAP_EN_BIT];

    // Both spaces use the same decoder with a different personality.
    // The code personality knows only the loader and the Flash.
    // The data personality adds the register windows and the RAM.
    // Sharing one decoder keeps the window limits in a single place.
    // Code space decoder; fetches never write.
    mmd_space_decoder #(
        .IS_CODE(1'b1),
        .FLASH_UNDER_LOADER(FLASH_UNDER_LOADER)
    ) codeDec (
        .addr(codeReq.addr),
        .mapEn(loaderRomMapEnable),
        .serialBoot(serialBoot),
        .region(codeRegion),
        .offset(codeOffset)
    );

    // Data space decoder.
    mmd_space_decoder #(
        .IS_CODE(1'b0),
        .FLASH_UNDER_LOADER(FLASH_UNDER_LOADER)
    ) dataDec (
        .addr(dataReq.addr),
        .mapEn(loaderRomMapEnable),
        .serialBoot(serialBoot),
        .region(dataRegion),
        .offset(dataOffset)
    );

    // The register bus sees only two words, the control buffer and the key.
    // The key address doubles as the readback of the shadow when read.
    // Reads never change state, so a read may be repeated without harm.
    // Writes act only in the access phase, at the edge that completes them.
    // APB access phase and address hits; registers sit at four times their index.
    assign apbAccess = psel && penable;
    assign hitCtrl = paddr == mmd_pkg::CTRL_ADDR;
    assign hitKey = paddr == mmd_pkg::KEY_ADDR;
    // Both registers are eight bits wide, so only byte lane zero carries data.
    assign lowLaneWrite = pstrb[0];

    // The slave never inserts wait states.
    assign pready = 1'b1;

    // Unmapped addresses answer with an error so stray software shows up early.
    assign pslverr = apbAccess && !(hitCtrl || hitKey);

    // The buffer holds the staged setting until the key commits it.
    // Software may rewrite it many times; only the last value is committed.
    // Control buffer: plain read/write storage that does not touch the map.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrlBuf_q <= mmd_pkg::CTRL_RESET;
        end else if (apbAccess && pwrite && hitCtrl && lowLaneWrite) begin
            ctrlBuf_q <= pwdata[7:0];
        end
    end

    // Any key value other than the commit code is ignored entirely.
    // This guards the map against a stray write from runaway software.
    // The shadow resets to the same value as the buffer, so both agree.
    // Shadow: loads from the buffer only on the key code, at the write's own edge.
    // Committing on the access edge means the very next fetch already sees the new map.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // Reset keeps the enable bit clear, so the loader is hidden.
            shadow_q <= mmd_pkg::CTRL_RESET;
        end else if (apbAccess && pwrite && hitKey && lowLaneWrite
                     && pwdata[7:0] == mmd_pkg::MAP_KEY_CODE) begin
            shadow_q <= ctrlBuf_q;
        end
    end

    // Read data is driven only in the access phase of a read.
    // Outside it the bus shows zero, which keeps the read mux quiet.
    // The upper three bytes are always zero; both registers are one byte.
    // Read data; the key word is write-only and its address reads the shadow instead.
    always_comb begin
        prdata = 32'h0000_0000;
        if (apbAccess && !pwrite) begin
            if (hitCtrl) begin
                prdata[7:0] = ctrlBuf_q;
            end else if (hitKey) begin
                prdata[7:0] = shadow_q;
            end
        end
    end

    // The selects are qualified by valid so that idle cycles draw no array power.
    // The offset is passed even when idle; an array ignores it without a select.
    // Array-side request for the code space; selects follow the decoder directly.
    always_comb begin
        codeMem = '0;
        codeMem.offset = codeOffset;
        if (codeReq.valid) begin
            codeMem.loaderSel = codeRegion == mmd_pkg::RGN_LOADER;
            codeMem.flashSel = codeRegion == mmd_pkg::RGN_FLASH;
        end
    end

    // Array-side request for the data space; writes pass to whichever target is selected, including the loader and Flash.
    always_comb begin
        dataMem = '0;
        dataMem.offset = dataOffset;
        dataMem.wdata = dataReq.wdata;
        dataMem.write = dataReq.valid && dataReq.write;
        if (dataReq.valid) begin
            // Reserved SFR slots are still selected; software is trusted to avoid them.
            dataMem.sfrSel = dataRegion == mmd_pkg::RGN_SFR;
            dataMem.ramSel = dataRegion == mmd_pkg::RGN_RAM;
            dataMem.loaderSel = dataRegion == mmd_pkg::RGN_LOADER;
            dataMem.flashSel = dataRegion == mmd_pkg::RGN_FLASH;
        end
    end

    // The region is remembered because the map may change before the data returns.
    // Steering by the stored region keeps each answer tied to its own request.
    // Remember which array answers next cycle for each space.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            codePend_q <= 1'b0;
            codeRegion_q <= mmd_pkg::RGN_NONE;
        end else begin
            codePend_q <= codeReq.valid;
            codeRegion_q <= codeRegion;
        end
    end

    // Data reads only; a write gets no answer word.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dataPend_q <= 1'b0;
            dataRegion_q <= mmd_pkg::RGN_NONE;
        end else begin
            dataPend_q <= dataReq.valid && !dataReq.write;
            dataRegion_q <= dataRegion;
        end
    end

    // Read data holds between answers; only valid pulses for one cycle.
    // The core must take the byte in the cycle that valid is high.
    // Places that decode to nothing read as the open bus fill value.
    // Fetch answer, registered one cycle after the arrays respond.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            codeRsp <= '0;
        end else begin
            codeRsp.valid <= codePend_q;
            if (codePend_q) begin
                unique case (codeRegion_q)
                    mmd_pkg::RGN_LOADER: codeRsp.rdata <= loaderCodeRdata;
                    mmd_pkg::RGN_FLASH: codeRsp.rdata <= flashCodeRdata;
                    mmd_pkg::RGN_TRAP: codeRsp.rdata <= TRAP_OPCODE;
                    default: codeRsp.rdata <= mmd_pkg::OPEN_BUS_FILL;
                endcase
            end
        end
    end

    // Data writes get no answer; the core does not wait for them.
    // Data answer, registered one cycle after the arrays respond.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dataRsp <= '0;
        end else begin
            dataRsp.valid <= dataPend_q;
            if (dataPend_q) begin
                unique case (dataRegion_q)
                    mmd_pkg::RGN_SFR: dataRsp.rdata <= sfrRdata;
                    mmd_pkg::RGN_RAM: dataRsp.rdata <= ramRdata;
                    mmd_pkg::RGN_LOADER: dataRsp.rdata <= loaderDataRdata;
                    mmd_pkg::RGN_FLASH: dataRsp.rdata <= flashDataRdata;
                    // A hidden loader window reads as all ones, like erased storage.
                    mmd_pkg::RGN_HOLE: dataRsp.rdata <= mmd_pkg::LOADER_HOLE_FILL;
                    default: dataRsp.rdata <= mmd_pkg::OPEN_BUS_FILL;
                endcase
            end
        end
    end

endmodule : mmd_memory_map_decoder
`default_nettype wire

// ==== mmd_map_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the decode windows and of the map commit.
module mmd_map_asserts #(
    parameter logic [7:0] TRAP_OPCODE = 8'hff
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire mmd_pkg::mmd_req_s codeReq,
    input wire mmd_pkg::mmd_req_s dataReq,
    input wire mmd_pkg::mmd_mem_s codeMem,
    input wire mmd_pkg::mmd_mem_s dataMem,
    input wire mmd_pkg::mmd_rsp_s codeRsp,
    input wire mmd_pkg::mmd_rsp_s dataRsp,
    input wire logic loaderRomMapEnable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Requests that fall in the loader window of each space.
    wire dLd = dataReq.valid && dataReq.addr inside {[16'h1000:16'h17ff]};
    wire cLd = codeReq.valid && codeReq.addr inside {[16'h1000:16'h17ff]};
    // Fill answers come out of the same two-stage read pipeline as real data.
    sequence s_hole;
        ##2 dataRsp.valid && dataRsp.rdata == 8'hff;
    endsequence
    sequence s_trap;
        ##2 codeRsp.valid && codeRsp.rdata == TRAP_OPCODE;
    endsequence
    property p_map_data;
        dLd && loaderRomMapEnable |-> dataMem.loaderSel && dataMem.offset == dataReq.addr - 16'h1000;
    endproperty
    property p_hole;
        dLd && !dataReq.write && !loaderRomMapEnable |-> s_hole;
    endproperty
    property p_map_code;
        cLd && loaderRomMapEnable |-> codeMem.loaderSel;
    endproperty
    property p_trap;
        cLd && !loaderRomMapEnable |-> s_trap;
    endproperty
    property p_flash_code;
        codeReq.valid && codeReq.addr >= 16'hc000 |-> codeMem.flashSel && codeMem.offset == codeReq.addr - 16'hc000;
    endproperty
    property p_flash_data;
        dataReq.valid && dataReq.addr >= 16'hc000 |-> dataMem.flashSel && dataMem.offset == dataReq.addr - 16'hc000;
    endproperty
    property p_sfr;
        dataReq.valid && (dataReq.addr <= 16'h003f || dataReq.addr inside {[16'h0e40:16'h0fff]})
            |-> dataMem.sfrSel && dataMem.offset == dataReq.addr;
    endproperty
    property p_ram;
        dataReq.valid && dataReq.addr inside {[16'h0040:16'h083f]} |-> dataMem.ramSel && dataMem.offset == dataReq.addr - 16'h0040;
    endproperty
    // Anything but the key code leaves the map in force untouched.
    property p_hold;
        psel && penable && pwrite && (paddr == 16'h3f40 || pwdata[7:0] != 8'hd5) |=> $stable(loaderRomMapEnable);
    endproperty
    property p_reset;
        $fell(reset) |-> !loaderRomMapEnable;
    endproperty
    a_map_data: assert property (p_map_data) else $error("loader data decode wrong");
    a_hole: assert property (p_hole) else $error("unmapped loader read not 0xff");
    a_map_code: assert property (p_map_code) else $error("loader code decode wrong");
    a_trap: assert property (p_trap) else $error("unmapped loader fetch wrong");
    a_flash_code: assert property (p_flash_code) else $error("code flash decode wrong");
    a_flash_data: assert property (p_flash_data) else $error("data flash decode wrong");
    a_sfr: assert property (p_sfr) else $error("sfr decode wrong");
    a_ram: assert property (p_ram) else $error("ram decode wrong");
    a_hold: assert property (p_hold) else $error("map changed without key");
    a_reset: assert property (p_reset) else $error("map enabled after reset");
endmodule : mmd_map_asserts

bind mmd_memory_map_decoder mmd_map_asserts #(.TRAP_OPCODE(TRAP_OPCODE)) i_mmd_map_asserts (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .codeReq(codeReq), .dataReq(dataReq), .codeMem(codeMem), .dataMem(dataMem),
    .codeRsp(codeRsp), .dataRsp(dataRsp), .loaderRomMapEnable(loaderRomMapEnable));

`default_nettype wire

// ==== mmd_array_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// One-cycle synchronous memory arrays; data is a per-array pattern of the offset.
module mmd_array_model (
    input wire logic clk,
    input wire mmd_pkg::mmd_mem_s codeMem,
    input wire mmd_pkg::mmd_mem_s dataMem,
    output logic [7:0] flashCodeRdata,
    output logic [7:0] loaderCodeRdata,
    output logic [7:0] sfrRdata,
    output logic [7:0] ramRdata,
    output logic [7:0] loaderDataRdata,
    output logic [7:0] flashDataRdata
);
    // A deselected array shows the inverted pattern, so a wrong select never reads as a match.
    always_ff @(posedge clk) begin
        flashCodeRdata <= codeMem.offset[7:0] ^ (codeMem.flashSel ? 8'h11 : 8'hee);
        loaderCodeRdata <= codeMem.offset[7:0] ^ (codeMem.loaderSel ? 8'h22 : 8'hdd);
        sfrRdata <= dataMem.offset[7:0] ^ (dataMem.sfrSel ? 8'h33 : 8'hcc);
        ramRdata <= dataMem.offset[7:0] ^ (dataMem.ramSel ? 8'h44 : 8'hbb);
        loaderDataRdata <= dataMem.offset[7:0] ^ (dataMem.loaderSel ? 8'h55 : 8'haa);
        flashDataRdata <= dataMem.offset[7:0] ^ (dataMem.flashSel ? 8'h66 : 8'h99);
    end
endmodule : mmd_array_model

`default_nettype wire

// ==== memory_map_decoder_test.sv ====
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the memory map decoder.
module memory_map_decoder_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic loaderRomMapEnable;
    mmd_pkg::mmd_req_s codeReq = '0;
    mmd_pkg::mmd_req_s dataReq = '0;
    mmd_pkg::mmd_mem_s codeMem;
    mmd_pkg::mmd_mem_s dataMem;
    mmd_pkg::mmd_rsp_s codeRsp;
    mmd_pkg::mmd_rsp_s dataRsp;
    logic [7:0] fc, lc, sr, rr, ld, fd;
    int miscompares = 0;
    int compares = 0;
    logic [24:0] tbl [11] = '{{1'b0, 16'h003f, 8'h0c}, {1'b0, 16'h0e40, 8'h73}, {1'b0, 16'h0fff, 8'hcc},
        {1'b0, 16'h0040, 8'h44}, {1'b0, 16'h083f, 8'hbb}, {1'b0, 16'hc000, 8'h66}, {1'b0, 16'hffff, 8'h99},
        {1'b0, 16'h0900, 8'h00}, {1'b1, 16'hc000, 8'h11}, {1'b1, 16'hffff, 8'hee}, {1'b1, 16'h0040, 8'h00}};

    mmd_memory_map_decoder i_mmd_memory_map_decoder (.clk(clk), .reset(reset), .serialBootPin(1'b0),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .codeReq(codeReq), .dataReq(dataReq),
        .codeMem(codeMem), .dataMem(dataMem), .flashCodeRdata(fc), .loaderCodeRdata(lc), .sfrRdata(sr),
        .ramRdata(rr), .loaderDataRdata(ld), .flashDataRdata(fd), .codeRsp(codeRsp), .dataRsp(dataRsp),
        .loaderRomMapEnable(loaderRomMapEnable));
    mmd_array_model i_mmd_array_model (.clk(clk), .codeMem(codeMem), .dataMem(dataMem),
        .flashCodeRdata(fc), .loaderCodeRdata(lc), .sfrRdata(sr), .ramRdata(rr),
        .loaderDataRdata(ld), .flashDataRdata(fd));

    task automatic close_out;
        if (miscompares == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r,
            output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            check("pready", 1, 0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check("prdata", exp, r);
    endtask : rd

    // One byte read in the code or data space, answered two edges after it is taken.
    task automatic acc(input logic code, input logic [15:0] a, input logic [7:0] exp);
        int n;
        @(posedge clk);
        if (code)
            codeReq <= '{1'b1, 1'b0, a, 8'h00};
        else
            dataReq <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge clk);
        codeReq.valid <= 1'b0;
        dataReq.valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((code ? codeRsp.valid : dataRsp.valid) !== 1'b1 && n < 8);
        if (n >= 8)
            check("rspValid", 1, 0);
        check("rsp", {24'h0, exp}, {24'h0, code ? codeRsp.rdata : dataRsp.rdata});
    endtask : acc

    task automatic t_after_reset;
        logic [31:0] r;
        logic e;
        rd(16'h3f40, 32'h40);
        rd(16'h3f44, 32'h40);
        check("mapEnable", 0, loaderRomMapEnable);
        acc(1'b0, 16'h1000, 8'hff);
        acc(1'b1, 16'h17ff, 8'hff);
        apb(1'b0, 16'h0000, 32'h0, r, e);
        check("pslverr", 1, e);
    endtask : t_after_reset

    // Buffer write, a wrong key, then the real key followed by loader accesses.
    task automatic t_key_commit;
        wr(16'h3f40, 32'h41);
        rd(16'h3f40, 32'h41);
        acc(1'b0, 16'h1000, 8'hff);
        wr(16'h3f44, 32'hd4);
        rd(16'h3f44, 32'h40);
        wr(16'h3f44, 32'hd5);
        acc(1'b0, 16'h17ff, 8'haa);
        acc(1'b1, 16'h1000, 8'h22);
        rd(16'h3f44, 32'h41);
        rd(16'h3f40, 32'h41);
    endtask : t_key_commit

    // Window edges of both spaces, plus one unmapped place in each space that reads as zero.
    task automatic t_decode;
        for (int i = 0; i < 11; i++)
            acc(tbl[i][24], tbl[i][23:8], tbl[i][7:0]);
    endtask : t_decode

    task automatic t_unmap;
        wr(16'h3f40, 32'h40);
        wr(16'h3f44, 32'hd5);
        acc(1'b0, 16'h1000, 8'hff);
        check("mapEnable", 0, loaderRomMapEnable);
    endtask : t_unmap

    initial begin
        forever #25 clk = ~clk;
    end

    // A hung run still ends through the closing report.
    initial begin
        #2000000;
        miscompares++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        t_after_reset();
        t_key_commit();
        t_decode();
        t_unmap();
        close_out();
    end
endmodule : memory_map_decoder_test

`default_nettype wire
